/* File: logic/status_service_defs.svh */
// constants for the status byte and service request block
// How it works
// - weights: error 1, stopped 2, started 4, fail 8, sweep 32, request 64, busy 128
// - only event bits 0 to 3 can raise a service request
// - four-bit enable mask; bit set enables error, stopped, started, fail
// - alpha command '@'..'O' and numeric command 0..15 write the same mask
// - numeric mask query returns the current mask as a byte
// - an enabled pending event asserts the service request
// - query form of a parameter command returns the stored parameter
// - short fault query gives one digit, full query the three-digit code
// - fault sources 0 to 4 report codes 010 to 014, sources 5 to 24 codes 021 to 040, every higher source 041
`ifndef STATUS_SERVICE_DEFS_SVH
`define STATUS_SERVICE_DEFS_SVH

`define BIT_ERROR 0
`define BIT_STOPPED 1
`define BIT_STARTED 2
`define BIT_FAIL 3
`define BIT_UNUSED 4
`define BIT_SWEEPING 5
`define BIT_SERVICE 6
`define BIT_BUSY 7

`define MASK_RESET 4'h0
`define MASK_MAX 16'h000f
`define ALPHA_FIRST 16'h0040
`define ALPHA_LAST 16'h004f

`define CODE_NONE 10'h000
`define CODE_OUT_OF_BOUNDS 10'h064
`define CODE_BAD_DIGIT 10'h321
`define DIGIT_DIVISOR 10'h064

`define FAIL_LOW_FIRST 10'h00a
`define FAIL_LOW_COUNT 5'h05
`define FAIL_HIGH_BASE 10'h010
`define FAIL_SOURCES 5'h19
`define FAIL_LAST 10'h029

`endif

/* File: logic/status_types_pkg.sv */
// command and answer types of the status block
`default_nettype none
package status_types_pkg;
    typedef enum logic [2:0] {
        param_cmd = 3'h0,
        mask_set_alpha_cmd = 3'h1,
        mask_set_numeric_cmd = 3'h2,
        status_byte_query = 3'h3,
        short_fault_query = 3'h4,
        full_error_query = 3'h5
    } cmd_e;
    typedef logic [9:0] code_t;
endpackage
`default_nettype wire

/* File: logic/event_latch.sv */
// sticky event flag where a set beats a clear
`default_nettype none
module event_latch #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic set,
    input wire logic clear,
    output logic flag_q
);
    logic flag_d;

    always_comb begin
        flag_d = set | (flag_q & ~clear);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flag_q <= RESET_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule
`default_nettype wire

/* File: logic/param_store.sv */
// small parameter memory with registered read data
`default_nettype none
module param_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset: contents are undefined until software writes them
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

/* File: logic/status_service_request.sv */
// status byte, event flags, enable mask and service request
`include "status_service_defs.svh"
`default_nettype none
module status_service_request #(
    parameter int PARAM_DEPTH = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire status_types_pkg::cmd_e cmd_code,
    input wire logic cmd_query,
    input wire logic [$clog2(PARAM_DEPTH)-1:0] cmd_index,
    input wire logic [15:0] cmd_arg,
    input wire logic err_event,
    input wire status_types_pkg::code_t err_code,
    input wire logic fail_event,
    input wire logic [4:0] fail_source,
    input wire logic sweep_active,
    input wire logic exec_busy,
    output logic resp_valid_q,
    output logic [15:0] resp_data_q,
    output logic srq_q,
    output logic [7:0] status_byte_q,
    output logic [3:0] mask_q
);
    import status_types_pkg::*;

    logic [3:0] mask_d;
    logic pend_q, pend_d, answer_q, answer_d, from_mem_q, from_mem_d;
    logic [15:0] snap_q, snap_d;
    logic resp_valid_d;
    logic [15:0] resp_data_d;
    code_t last_code_q, last_code_d;
    logic sweep_q, busy_q, busy_d, srq_d;
    logic [7:0] status_byte_d;
    logic [3:0] ev_q, ev_set;
    logic ev_clear, bad_cmd;
    code_t bad_code;
    logic mem_wr, mem_rd;
    logic [15:0] mem_data;

    // fault source index to its failure code
    function automatic code_t fail_code(input logic [4:0] src);
        code_t c;
        c = `FAIL_LAST;
        if (src < `FAIL_LOW_COUNT) begin
            c = `FAIL_LOW_FIRST + {5'h00, src};
        end else if (src < `FAIL_SOURCES) begin
            c = `FAIL_HIGH_BASE + {5'h00, src};
        end
        return c;
    endfunction

    // command decode and answer capture
    always_comb begin
        mask_d = mask_q;
        bad_cmd = 1'b0;
        bad_code = `CODE_NONE;
        pend_d = 1'b0;
        answer_d = 1'b0;
        from_mem_d = 1'b0;
        snap_d = snap_q;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        ev_clear = 1'b0;
        if (cmd_valid) begin
            pend_d = 1'b1;
            case (cmd_code)
                param_cmd: begin
                    answer_d = cmd_query;
                    from_mem_d = cmd_query;
                    mem_rd = cmd_query;
                    mem_wr = !cmd_query;
                end
                mask_set_alpha_cmd: begin
                    answer_d = cmd_query;
                    snap_d = {12'h000, mask_q};
                    if (!cmd_query) begin
                        if (cmd_arg >= `ALPHA_FIRST
                                && cmd_arg <= `ALPHA_LAST) begin
                            mask_d = cmd_arg[3:0];
                        end else begin
                            bad_cmd = 1'b1;
                            bad_code = `CODE_BAD_DIGIT;
                        end
                    end
                end
                mask_set_numeric_cmd: begin
                    answer_d = cmd_query;
                    snap_d = {12'h000, mask_q};
                    if (!cmd_query) begin
                        if (cmd_arg <= `MASK_MAX) begin
                            mask_d = cmd_arg[3:0];
                        end else begin
                            bad_cmd = 1'b1;
                            bad_code = `CODE_OUT_OF_BOUNDS;
                        end
                    end
                end
                status_byte_query: begin
                    answer_d = 1'b1;
                    snap_d = {8'h00, status_byte_q};
                    ev_clear = 1'b1;
                end
                short_fault_query: begin
                    answer_d = 1'b1;
                    snap_d = {6'h00, last_code_q / `DIGIT_DIVISOR};
                end
                full_error_query: begin
                    answer_d = 1'b1;
                    snap_d = {6'h00, last_code_q};
                end
                default: begin
                    bad_cmd = 1'b1;
                    bad_code = `CODE_BAD_DIGIT;
                end
            endcase
        end
        resp_valid_d = pend_q & answer_q;
        resp_data_d = resp_data_q;
        if (pend_q && answer_q) begin
            resp_data_d = from_mem_q ? mem_data : snap_q;
        end
    end

    // a failure outranks a rejected command, which outranks outside errors
    always_comb begin
        last_code_d = last_code_q;
        if (fail_event) begin
            last_code_d = fail_code(fail_source);
        end else if (bad_cmd) begin
            last_code_d = bad_code;
        end else if (err_event) begin
            last_code_d = err_code;
        end
    end

    // event sources; sweep edges come from the sweeping level
    always_comb begin
        ev_set[`BIT_ERROR] = err_event | bad_cmd;
        ev_set[`BIT_STOPPED] = sweep_q & ~sweep_active;
        ev_set[`BIT_STARTED] = sweep_active & ~sweep_q;
        ev_set[`BIT_FAIL] = fail_event;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ev
            event_latch #(
                .RESET_VAL(1'b0)
            ) u_latch (
                .clock(clock),
                .resetn(resetn),
                .set(ev_set[g]),
                .clear(ev_clear),
                .flag_q(ev_q[g])
            );
        end
    endgenerate

    param_store #(
        .WIDTH(16),
        .DEPTH(PARAM_DEPTH)
    ) u_params (
        .clock(clock),
        .wr_en(mem_wr),
        .wr_addr(cmd_index),
        .wr_data(cmd_arg),
        .rd_en(mem_rd),
        .rd_addr(cmd_index),
        .rd_data_q(mem_data)
    );

    // status byte assembly, one cycle behind the flags
    always_comb begin
        busy_d = cmd_valid | pend_q | exec_busy;
        srq_d = |(ev_q & mask_q);
        status_byte_d = 8'h00;
        status_byte_d[3:0] = ev_q;
        status_byte_d[`BIT_SWEEPING] = sweep_q;
        status_byte_d[`BIT_SERVICE] = srq_d;
        status_byte_d[`BIT_BUSY] = busy_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mask_q <= `MASK_RESET;
            pend_q <= 1'b0;
            answer_q <= 1'b0;
            from_mem_q <= 1'b0;
            snap_q <= 16'h0000;
            resp_valid_q <= 1'b0;
            resp_data_q <= 16'h0000;
            last_code_q <= `CODE_NONE;
            sweep_q <= 1'b0;
            busy_q <= 1'b0;
            srq_q <= 1'b0;
            status_byte_q <= 8'h00;
        end else begin
            mask_q <= mask_d;
            pend_q <= pend_d;
            answer_q <= answer_d;
            from_mem_q <= from_mem_d;
            snap_q <= snap_d;
            resp_valid_q <= resp_valid_d;
            resp_data_q <= resp_data_d;
            last_code_q <= last_code_d;
            sweep_q <= sweep_active;
            busy_q <= busy_d;
            srq_q <= srq_d;
            status_byte_q <= status_byte_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_layout;
        status_byte_q[`BIT_UNUSED] == 1'b0
            && status_byte_q[`BIT_SERVICE] == srq_q;
    endproperty
    a_layout: assert property (p_layout)
        else $error("status layout");

    property p_only_events;
        srq_q == |(status_byte_q[3:0] & $past(mask_q));
    endproperty
    a_only_events: assert property (p_only_events)
        else $error("srq source");

    property p_numeric_set;
        cmd_valid && cmd_code == mask_set_numeric_cmd && !cmd_query
            && cmd_arg <= `MASK_MAX |=> mask_q == $past(cmd_arg[3:0]);
    endproperty
    a_numeric_set: assert property (p_numeric_set)
        else $error("mask set");

    // an error already pending may stay, a good letter adds none
    property p_alpha_set;
        cmd_valid && cmd_code == mask_set_alpha_cmd && !cmd_query
            && cmd_arg >= `ALPHA_FIRST && cmd_arg <= `ALPHA_LAST
            |=> mask_q == $past(cmd_arg[3:0])
            && ev_q[`BIT_ERROR] == $past(ev_q[`BIT_ERROR] | err_event);
    endproperty
    a_alpha_set: assert property (p_alpha_set)
        else $error("alpha mask");

    property p_mask_query;
        cmd_valid && cmd_code == mask_set_numeric_cmd && cmd_query
            |-> ##2 resp_valid_q && resp_data_q == {12'h000, $past(mask_q, 2)};
    endproperty
    a_mask_query: assert property (p_mask_query)
        else $error("mask readback");

    property p_request;
        err_event && !(cmd_valid && cmd_code == status_byte_query)
            ##1 mask_q[0] |=> srq_q;
    endproperty
    a_request: assert property (p_request)
        else $error("no srq");

    property p_readback;
        cmd_valid && cmd_code == param_cmd && cmd_query |-> ##2 resp_valid_q;
    endproperty
    a_readback: assert property (p_readback)
        else $error("no readback");

    property p_full_code;
        cmd_valid && cmd_code == full_error_query
            |-> ##2 resp_data_q == {6'h00, $past(last_code_q, 2)};
    endproperty
    a_full_code: assert property (p_full_code)
        else $error("error code");

    property p_fail_code;
        fail_event && fail_source == 5'h01 |=> last_code_q == 10'h00b;
    endproperty
    a_fail_code: assert property (p_fail_code)
        else $error("fail code");

    property p_read_clears;
        cmd_valid && cmd_code == status_byte_query && !err_event
            |=> !ev_q[`BIT_ERROR];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("not cleared");

    property p_busy;
        cmd_valid |=> busy_q ##1 status_byte_q[`BIT_BUSY];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy missing");

    c_srq: cover property (err_event && mask_q[0] ##2 srq_q);
    c_sweep: cover property (sweep_active ##1 !sweep_active);
    c_status: cover property (cmd_valid && cmd_code == status_byte_query
        ##2 resp_valid_q);
endmodule
`default_nettype wire

/* File: verif/host_model.sv */
// host controller model that issues commands to the status block
`default_nettype none
module host_model (
    input wire logic clock,
    input wire logic resp_valid_q,
    input wire logic [15:0] resp_data_q,
    output var logic cmd_valid,
    output var status_types_pkg::cmd_e cmd_code,
    output var logic cmd_query,
    output var logic [3:0] cmd_index,
    output var logic [15:0] cmd_arg
);
    timeunit 1ns;
    timeprecision 1ps;
    import status_types_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = param_cmd;
        cmd_query = 1'b0;
        cmd_index = 4'h0;
        cmd_arg = 16'h0000;
    end
    task automatic issue(input cmd_e code, input logic q,
                         input logic [3:0] idx, input logic [15:0] arg);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_query = q;
        cmd_index = idx;
        cmd_arg = arg;
        @(negedge clock);
        cmd_valid = 1'b0;
        // stale fields scrambled so nothing leans on held values
        cmd_index = ~idx;
        cmd_arg = ~arg;
    endtask
    task automatic set_mask(input logic alpha, input logic [3:0] m);
        if (alpha) begin
            issue(mask_set_alpha_cmd, 1'b0, 4'h0, {12'h004, m});
        end else begin
            issue(mask_set_numeric_cmd, 1'b0, 4'h0, {12'h000, m});
        end
    endtask
    task automatic ask(input cmd_e code, input logic [3:0] idx,
                       output logic [15:0] data, output logic ok);
        logic early;
        issue(code, 1'b1, idx, 16'h0000);
        early = resp_valid_q;
        @(negedge clock);
        ok = (early === 1'b0) && (resp_valid_q === 1'b1);
        data = resp_data_q;
    endtask
endmodule
`default_nettype wire

/* File: verif/status_service_request_test.sv */
// self-checking bench for the status and service request block
`default_nettype none
module status_service_request_test;
    timeunit 1ns;
    timeprecision 1ps;
    import status_types_pkg::*;
    typedef struct packed {
        logic alpha;
        logic [3:0] mask;
        logic fail;
        logic [7:0] exp;
    } row_s;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic err_event = 1'b0;
    code_t err_code = 10'h000;
    logic fail_event = 1'b0;
    logic [4:0] fail_source = 5'h00;
    logic sweep_active = 1'b0;
    logic exec_busy = 1'b0;
    logic cmd_valid, cmd_query, resp_valid_q, srq_q, ok;
    cmd_e cmd_code;
    logic [3:0] cmd_index, mask_q;
    logic [15:0] cmd_arg, resp_data_q, data;
    logic [7:0] status_byte_q;
    int bad_count = 0;
    int num_checks = 0;
    row_s rows [8] = '{'{1'b1, 4'h1, 1'b0, 8'h41}, '{1'b0, 4'h9, 1'b0, 8'h41},
        '{1'b1, 4'h9, 1'b1, 8'h48}, '{1'b0, 4'h8, 1'b0, 8'h01},
        '{1'b1, 4'h7, 1'b1, 8'h08}, '{1'b0, 4'h0, 1'b0, 8'h01},
        '{1'b1, 4'hf, 1'b1, 8'h48}, '{1'b0, 4'he, 1'b0, 8'h01}};
    logic [4:0] srcs [4] = '{5'h00, 5'h05, 5'h18, 5'h19};
    logic [15:0] codes [4] = '{16'h000a, 16'h0015, 16'h0028, 16'h0029};

    always #4 clock = ~clock;

    host_model host (.clock(clock), .resp_valid_q(resp_valid_q),
        .resp_data_q(resp_data_q), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_query(cmd_query),
        .cmd_index(cmd_index), .cmd_arg(cmd_arg));
    status_service_request uut (.clock(clock), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_query(cmd_query),
        .cmd_index(cmd_index), .cmd_arg(cmd_arg), .err_event(err_event),
        .err_code(err_code), .fail_event(fail_event),
        .fail_source(fail_source), .sweep_active(sweep_active),
        .exec_busy(exec_busy), .resp_valid_q(resp_valid_q),
        .resp_data_q(resp_data_q), .srq_q(srq_q),
        .status_byte_q(status_byte_q), .mask_q(mask_q));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic query(input cmd_e code, input logic [3:0] idx,
                         input logic [15:0] exp);
        host.ask(code, idx, data, ok);
        check({15'h0000, ok}, 16'h0001);
        check(data, exp);
    endtask
    task automatic pulse(input logic f, input code_t v);
        @(negedge clock);
        err_event = ~f;
        fail_event = f;
        err_code = v;
        fail_source = v[4:0];
        @(negedge clock);
        err_event = 1'b0;
        fail_event = 1'b0;
    endtask

    initial begin
        idle(4);
        resetn = 1'b1;
        check({8'h00, status_byte_q}, 16'h0000);
        check({12'h000, mask_q}, 16'h0000);
        foreach (rows[i]) begin
            host.set_mask(rows[i].alpha, rows[i].mask);
            idle(2);
            check({12'h000, mask_q}, {12'h000, rows[i].mask});
            query(mask_set_numeric_cmd, 4'h0, {12'h000, rows[i].mask});
            idle(6);
            pulse(rows[i].fail, rows[i].fail ? 10'h003 : 10'h2bc);
            idle(2);
            check({8'h00, status_byte_q}, {8'h00, rows[i].exp});
            check({15'h0000, srq_q}, {15'h0000, rows[i].exp[6]});
            query(status_byte_query, 4'h0, {8'h00, rows[i].exp});
            idle(6);
            check({7'h00, srq_q, status_byte_q}, 16'h0000);
        end
        for (int m = 0; m < 16; m++) begin
            host.set_mask(1'b1, 4'(m));
            idle(1);
            check({12'h000, mask_q}, 16'(m));
        end
        host.set_mask(1'b0, 4'h5);
        // refused letter, refused number, then a plain entry error
        host.issue(mask_set_alpha_cmd, 1'b0, 4'h0, 16'h0050);
        idle(2);
        check({12'h000, mask_q}, 16'h0005);
        check({14'h0000, srq_q, status_byte_q[0]}, 16'h0003);
        query(full_error_query, 4'h0, 16'h0321);
        query(short_fault_query, 4'h0, 16'h0008);
        query(mask_set_alpha_cmd, 4'h0, 16'h0005);
        host.issue(mask_set_numeric_cmd, 1'b0, 4'h0, 16'h0010);
        idle(2);
        check({12'h000, mask_q}, 16'h0005);
        query(full_error_query, 4'h0, 16'h0064);
        query(short_fault_query, 4'h0, 16'h0001);
        // unknown command code is an entry error
        host.issue(cmd_e'(3'h7), 1'b0, 4'h0, 16'h0000);
        idle(2);
        check({12'h000, mask_q}, 16'h0005);
        query(full_error_query, 4'h0, 16'h0321);
        pulse(1'b0, 10'h2bc);
        query(full_error_query, 4'h0, 16'h02bc);
        query(short_fault_query, 4'h0, 16'h0007);
        for (int k = 0; k < 4; k++) begin
            pulse(1'b1, {5'h00, srcs[k]});
            query(full_error_query, 4'h0, codes[k]);
        end
        query(short_fault_query, 4'h0, 16'h0000);
        idle(6);
        query(status_byte_query, 4'h0, 16'h0049);
        host.set_mask(1'b1, 4'h4);
        idle(6);
        sweep_active = 1'b1;
        idle(3);
        check({8'h00, status_byte_q}, 16'h0064);
        query(status_byte_query, 4'h0, 16'h0064);
        idle(6);
        check({7'h00, srq_q, status_byte_q}, 16'h0020);
        sweep_active = 1'b0;
        exec_busy = 1'b1;
        idle(3);
        check({7'h00, srq_q, status_byte_q}, 16'h0082);
        exec_busy = 1'b0;
        idle(4);
        // a set landing with the read must survive the clear
        fork
            query(status_byte_query, 4'h0, 16'h0002);
            pulse(1'b0, 10'h2bc);
        join
        idle(6);
        check({8'h00, status_byte_q}, 16'h0001);
        host.issue(param_cmd, 1'b0, 4'h3, 16'hbeef);
        host.issue(param_cmd, 1'b0, 4'h4, 16'h1234);
        query(param_cmd, 4'h3, 16'hbeef);
        @(negedge clock);
        resetn = 1'b0;
        @(negedge clock);
        check({4'h0, mask_q, status_byte_q}, 16'h0000);
        resetn = 1'b1;
        idle(2);
        check({7'h00, srq_q, status_byte_q}, 16'h0000);
        final_report();
    end

    initial begin
        #200000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
